/* hdl/bcr_pkg.sv */
// Constants for the bridge configuration header register bank
package bcr_pkg;
   // Byte offsets within the function's configuration space
   localparam logic [7:0] STATUS_OFFSET = 8'h06;
   localparam logic [7:0] REVISION_OFFSET = 8'h08;
   localparam logic [7:0] SUB_CLASS_OFFSET = 8'h0a;
   localparam logic [7:0] BASE_CLASS_OFFSET = 8'h0b;
   localparam logic [7:0] LATENCY_OFFSET = 8'h0d;
   localparam logic [7:0] HEADER_OFFSET = 8'h0e;
   localparam logic [7:0] PRIMARY_BUS_OFFSET = 8'h18;
   localparam logic [7:0] SECONDARY_BUS_OFFSET = 8'h19;

   // Field positions in the primary status register and the latency register
   localparam int DETECTED_PARITY_ERROR_BIT = 15;
   localparam int SIGNALED_SYSTEM_ERROR_BIT = 14;
   localparam int RECEIVED_MASTER_ABORT_BIT = 13;
   localparam int RECEIVED_TARGET_ABORT_BIT = 12;
   localparam int SIGNALED_TARGET_ABORT_BIT = 11;
   localparam int SELECT_TIMING_MSB = 10;
   localparam int SELECT_TIMING_LSB = 9;
   localparam int DATA_PARITY_DETECTED_BIT = 8;
   localparam int FAST_BACK_TO_BACK_BIT = 7;
   localparam int SPEED_66MHZ_CAPABLE_BIT = 5;
   localparam int LATENCY_SCRATCH_LSB = 3;

   // Reset and fixed values
   localparam logic [15:0] STATUS_RESET = 16'h00a0;
   localparam logic [1:0] SELECT_TIMING_VALUE = 2'h0;
   localparam logic [7:0] SUB_CLASS_VALUE = 8'h04;
   localparam logic [7:0] BASE_CLASS_VALUE = 8'h06;
   localparam logic [7:0] LATENCY_RESET = 8'h00;
   localparam logic [7:0] HEADER_VALUE = 8'h01;
   localparam logic [7:0] PRIMARY_BUS_VALUE = 8'h00;
   localparam logic [7:0] SECONDARY_BUS_RESET = 8'h00;

   // Number of individually enabled error conditions
   localparam int ERROR_SOURCES = 4;
endpackage

/* hdl/bcr_config_header.sv */
// Configuration header registers of the virtual bridge to the stream link
`timescale 1ns/1ns

// Behaviour
// - Set signaled_system_error whenever a message goes out on hub_link.
// - Only enabled error conditions may raise the message and flag.
// - Writing one clears a write-one-to-clear bit; writing zero leaves it.
// - detected_parity_error and data_parity_detected always read zero.
// - Both received aborts and signaled_target_abort always read zero.
// - select_timing field always reads 00b, the fastest decode.
// - fast_back_to_back capability bit always reads one.
// - speed_66mhz_capable bit always reads one.
// - bridge_revision always mirrors the device's main revision register.
// - bridge_sub_class reads a fixed 04h.
// - bridge_base_class reads a fixed 06h.
// - Latency bits 7:3 are a scratchpad returning the last written value.
// - bridge_header_layout reads a fixed 01h.
// - bridge_primary_bus_num reads 00h and ignores writes.
// - Secondary bus number is writable; matching cycles go to the link, except those for bus 0.
// - system_error_enable globally gates every system-error message.
module bcr_config_header
   import bcr_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic cfgRead,
   input wire logic cfgWrite,
   input wire logic [7:0] cfgAddr,
   input wire logic [3:0] cfgByteEnable,
   input wire logic [31:0] cfgWrData,
   input wire logic [7:0] mainRevision,
   input wire logic systemErrorEnable,
   input wire logic [ERROR_SOURCES-1:0] errorEvent,
   input wire logic [ERROR_SOURCES-1:0] errorEnable,
   input wire logic fwdRequest,
   input wire logic [7:0] fwdBus,
   output logic [31:0] cfgRdData,
   output logic cfgRdValid,
   output logic hubLinkSerrMessage,
   output logic signaledSystemError,
   output logic [7:0] secondaryBusNum,
   output logic fwdToLink,
   output logic fwdRefused
);

   // True when a dword address selects the dword holding a byte offset
   function automatic logic dwordHit(input logic [7:0] addr,
                                     input logic [7:0] offset);
      return addr[7:2] == offset[7:2];
   endfunction

   // Byte enable for the lane that holds a byte offset
   function automatic logic laneEnable(input logic [3:0] be,
                                       input logic [7:0] offset);
      return be[offset[1:0]];
   endfunction

   logic sysErrFlag;
   logic [4:0] latencyScratch;
   logic [7:0] secBus;
   logic [31:0] next_cfgRdData;

   wire logic statusHit = dwordHit(cfgAddr, STATUS_OFFSET);
   wire logic revisionHit = dwordHit(cfgAddr, REVISION_OFFSET);
   wire logic latencyHit = dwordHit(cfgAddr, LATENCY_OFFSET);
   wire logic busHit = dwordHit(cfgAddr, PRIMARY_BUS_OFFSET);

   // Status upper byte sits in byte lane 3 of its dword
   wire logic flagClearWrite = cfgWrite && statusHit
      && laneEnable(cfgByteEnable, STATUS_OFFSET + 8'h01)
      && cfgWrData[16 + SIGNALED_SYSTEM_ERROR_BIT];
   wire logic latencyWrite = cfgWrite && latencyHit
      && laneEnable(cfgByteEnable, LATENCY_OFFSET);
   // Primary bus lane is never written; only the secondary lane is
   wire logic secBusWrite = cfgWrite && busHit
      && laneEnable(cfgByteEnable, SECONDARY_BUS_OFFSET);

   wire logic enabledError = |(errorEvent & errorEnable);
   wire logic serrFire = enabledError && systemErrorEnable;

   // Hardwired bits are built here, never stored
   wire logic [15:0] statusValue = {1'b0,
      sysErrFlag,
      3'b000,
      SELECT_TIMING_VALUE,
      1'b0,
      STATUS_RESET[FAST_BACK_TO_BACK_BIT],
      1'b0,
      STATUS_RESET[SPEED_66MHZ_CAPABLE_BIT],
      5'b00000};
   wire logic [7:0] latencyValue = {latencyScratch, 3'b000};

   wire logic [31:0] statusWord = {statusValue, 16'h0000};
   wire logic [31:0] classWord = {BASE_CLASS_VALUE,
      SUB_CLASS_VALUE,
      8'h00, mainRevision};
   wire logic [31:0] headerWord = {8'h00, HEADER_VALUE,
      latencyValue, 8'h00};
   wire logic [31:0] busWord = {16'h0000, secBus,
      PRIMARY_BUS_VALUE};

   // Unmapped dwords read zero
   always_comb begin
      next_cfgRdData = 32'h00000000;
      if (statusHit) begin
         next_cfgRdData = statusWord;
      end else if (revisionHit) begin
         next_cfgRdData = classWord;
      end else if (latencyHit) begin
         next_cfgRdData = headerWord;
      end else if (busHit) begin
         next_cfgRdData = busWord;
      end
   end

   // Bus 0 is the primary bus, so it is never sent down the link
   wire logic fwdMatch = fwdBus == secBus
      && fwdBus != PRIMARY_BUS_VALUE;

   always_ff @(posedge clock) begin
      if (!resetn) begin
         sysErrFlag <= STATUS_RESET[SIGNALED_SYSTEM_ERROR_BIT];
      end else if (serrFire) begin
         sysErrFlag <= 1'b1;
      end else if (flagClearWrite) begin
         sysErrFlag <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         latencyScratch <= LATENCY_RESET[7:LATENCY_SCRATCH_LSB];
      end else if (latencyWrite) begin
         latencyScratch <= cfgWrData[15:8 + LATENCY_SCRATCH_LSB];
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         secBus <= SECONDARY_BUS_RESET;
      end else if (secBusWrite) begin
         secBus <= cfgWrData[15:8];
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         cfgRdData <= 32'h00000000;
         cfgRdValid <= 1'b0;
      end else begin
         cfgRdData <= cfgRead ? next_cfgRdData : 32'h00000000;
         cfgRdValid <= cfgRead;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         hubLinkSerrMessage <= 1'b0;
         signaledSystemError <= 1'b0;
      end else begin
         hubLinkSerrMessage <= serrFire;
         signaledSystemError <= serrFire || (sysErrFlag && !flagClearWrite);
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         secondaryBusNum <= SECONDARY_BUS_RESET;
         fwdToLink <= 1'b0;
         fwdRefused <= 1'b0;
      end else begin
         secondaryBusNum <= secBusWrite ? cfgWrData[15:8] : secBus;
         fwdToLink <= fwdRequest && fwdMatch;
         fwdRefused <= fwdRequest && !fwdMatch;
      end
   end

   // Helper state for the checks below
   logic [7:0] lastReadAddr;
   logic [7:0] lastRevision;
   always_ff @(posedge clock) begin
      if (!resetn) begin
         lastReadAddr <= 8'h00;
         lastRevision <= 8'h00;
      end else begin
         lastReadAddr <= cfgAddr;
         lastRevision <= mainRevision;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   property p_flag_on_message;
      serrFire |=> hubLinkSerrMessage ##0 signaledSystemError ##0 sysErrFlag;
   endproperty
   a_flag_on_message: assert property (p_flag_on_message)
      else $error("system error flag not set with message");

   property p_only_enabled;
      hubLinkSerrMessage |-> $past(enabledError);
   endproperty
   a_only_enabled: assert property (p_only_enabled)
      else $error("message without an enabled error condition");

   property p_global_gate;
      !systemErrorEnable |=> !hubLinkSerrMessage;
   endproperty
   a_global_gate: assert property (p_global_gate)
      else $error("message sent while system error disabled");

   property p_w1c_clear;
      flagClearWrite && !serrFire |=> !sysErrFlag
         ##1 (!sysErrFlag || $past(serrFire));
   endproperty
   a_w1c_clear: assert property (p_w1c_clear)
      else $error("write one did not clear the flag");

   property p_w0_keep;
      cfgWrite && statusHit && !flagClearWrite && sysErrFlag |=> sysErrFlag;
   endproperty
   a_w0_keep: assert property (p_w0_keep)
      else $error("flag lost without a write of one");

   property p_status_fixed;
      cfgRdValid && dwordHit(lastReadAddr, STATUS_OFFSET) |->
         (cfgRdData[31:16] & 16'hbfff) == STATUS_RESET;
   endproperty
   a_status_fixed: assert property (p_status_fixed)
      else $error("hardwired status bits read wrong");

   property p_class_word;
      cfgRdValid && dwordHit(lastReadAddr, REVISION_OFFSET) |->
         cfgRdData == {BASE_CLASS_VALUE, SUB_CLASS_VALUE, 8'h00,
                       lastRevision};
   endproperty
   a_class_word: assert property (p_class_word)
      else $error("revision or class code read wrong");

   property p_scratch;
      latencyWrite ##1 (cfgRead && latencyHit && !latencyWrite) |=>
         cfgRdData == {8'h00, HEADER_VALUE,
                       $past(cfgWrData[15:11], 2), 3'b000, 8'h00};
   endproperty
   a_scratch: assert property (p_scratch)
      else $error("latency scratchpad did not return written value");

   property p_bus_word;
      cfgRdValid && dwordHit(lastReadAddr, PRIMARY_BUS_OFFSET) |->
         cfgRdData[7:0] == PRIMARY_BUS_VALUE
         && cfgRdData[15:8] == $past(secBus);
   endproperty
   a_bus_word: assert property (p_bus_word)
      else $error("bus number register read wrong");

   property p_forward;
      fwdRequest && fwdBus == secBus && fwdBus != 8'h00 |=> fwdToLink;
   endproperty
   a_forward: assert property (p_forward)
      else $error("matching config cycle not sent to link");

   property p_bus0_refused;
      fwdRequest && fwdBus == PRIMARY_BUS_VALUE |=> fwdRefused && !fwdToLink;
   endproperty
   a_bus0_refused: assert property (p_bus0_refused)
      else $error("bus zero cycle sent to link");

   property p_other_refused;
      fwdRequest && fwdBus != secBus |=> fwdRefused && !fwdToLink;
   endproperty
   a_other_refused: assert property (p_other_refused)
      else $error("cycle for another bus sent to link");

   property p_sec_out;
      secBusWrite |=> secondaryBusNum == $past(cfgWrData[15:8]);
   endproperty
   a_sec_out: assert property (p_sec_out)
      else $error("secondary bus number not written");

   property p_latency_word;
      cfgRdValid && dwordHit(lastReadAddr, LATENCY_OFFSET) |->
         cfgRdData[31:24] == 8'h00 && cfgRdData[10:0] == 11'h000;
   endproperty
   a_latency_word: assert property (p_latency_word)
      else $error("reserved latency bits read nonzero");

   // Holes between the mapped dwords must read as zero
   property p_unmapped;
      cfgRdValid && !dwordHit(lastReadAddr, STATUS_OFFSET)
         && !dwordHit(lastReadAddr, REVISION_OFFSET)
         && !dwordHit(lastReadAddr, LATENCY_OFFSET)
         && !dwordHit(lastReadAddr, PRIMARY_BUS_OFFSET) |->
         cfgRdData == 32'h00000000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped dword read nonzero");

   property p_flag_out;
      signaledSystemError == sysErrFlag;
   endproperty
   a_flag_out: assert property (p_flag_out)
      else $error("flag output differs from status bit");

   c_message: cover property (serrFire ##1 hubLinkSerrMessage);
   c_clear: cover property (sysErrFlag ##1 flagClearWrite ##1 !sysErrFlag);
   c_forward: cover property (secBusWrite ##[1:5] fwdToLink);
   c_scratch: cover property (latencyWrite ##[1:3] cfgRdValid);

endmodule

/* verification/bcr_config_header_tb_top.sv */
// Random self-checking bench for the bridge configuration header bank
`timescale 1ns/1ns
module bcr_config_header_tb_top
   import bcr_pkg::*;
;
   logic clock;
   logic resetn;
   logic cfgRead;
   logic cfgWrite;
   logic [7:0] cfgAddr;
   logic [3:0] cfgByteEnable;
   logic [31:0] cfgWrData;
   logic [7:0] mainRevision;
   logic systemErrorEnable;
   logic [3:0] errorEvent;
   logic [3:0] errorEnable;
   logic fwdRequest;
   logic [7:0] fwdBus;
   logic [31:0] cfgRdData;
   logic cfgRdValid;
   logic hubLinkSerrMessage;
   logic signaledSystemError;
   logic [7:0] secondaryBusNum;
   logic fwdToLink;
   logic fwdRefused;
   int mFlag;
   int mLat;
   int mSec;
   int errTotal;
   int checksDone;
   logic [31:0] seed;
   // Mapped dwords, their alias halves and unmapped holes
   logic [7:0] addrTab [8] = '{8'h04, 8'h08, 8'h0c, 8'h18, 8'h10, 8'h00,
      8'h1c, 8'h06};

   bcr_config_header u_bcr_config_header (.clock(clock), .resetn(resetn),
      .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
      .cfgByteEnable(cfgByteEnable), .cfgWrData(cfgWrData),
      .mainRevision(mainRevision), .systemErrorEnable(systemErrorEnable),
      .errorEvent(errorEvent), .errorEnable(errorEnable),
      .fwdRequest(fwdRequest), .fwdBus(fwdBus), .cfgRdData(cfgRdData),
      .cfgRdValid(cfgRdValid), .hubLinkSerrMessage(hubLinkSerrMessage),
      .signaledSystemError(signaledSystemError),
      .secondaryBusNum(secondaryBusNum), .fwdToLink(fwdToLink),
      .fwdRefused(fwdRefused));

   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function logic [31:0] rdModel(input logic [7:0] a);
      case (a[7:2])
         6'h01: return (mFlag << 30) | 32'h00a00000;
         6'h02: return {8'h06, 8'h04, 8'h00, mainRevision};
         6'h03: return 32'h00010000 | (mLat << 8);
         6'h06: return mSec << 8;
         default: return 32'h0;
      endcase
   endfunction

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errTotal++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task endSim();
      if (errTotal == 0 && checksDone > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task drive(input int n);
      logic [31:0] r;
      r = rnd();
      cfgRead = r[0] & (n % 16 != 0);
      cfgWrite = r[1];
      cfgAddr = addrTab[r[4:2]] | {6'h0, r[6:5]};
      cfgByteEnable = r[10:7];
      cfgWrData = rnd();
      errorEvent = r[14:11] & r[27:24];
      errorEnable = r[18:15];
      systemErrorEnable = r[19] | r[20];
      // Keep forwarding apart from writes so the bus number is unambiguous
      fwdRequest = r[21] & ~r[1];
      fwdBus = r[22] ? mSec[7:0] : (r[23] ? 8'h00 : r[31:24]);
      if (n % 16 == 0) begin
         mainRevision = r[31:24];
      end
   endtask

   task tick();
      logic [31:0] expRd;
      logic expMsg;
      logic expFwd;
      logic isWr;
      isWr = cfgWrite & resetn;
      expRd = (cfgRead & resetn) ? rdModel(cfgAddr) : 32'h0;
      expMsg = resetn & systemErrorEnable & (|(errorEvent & errorEnable));
      expFwd = fwdRequest && fwdBus == mSec[7:0] && fwdBus != 8'h00;
      if (isWr && cfgAddr[7:2] == 6'h01 && cfgByteEnable[3] && cfgWrData[30])
         mFlag = 0;
      if (expMsg)
         mFlag = 1;
      if (isWr && cfgAddr[7:2] == 6'h03 && cfgByteEnable[1])
         mLat = cfgWrData[15:11] << 3;
      if (isWr && cfgAddr[7:2] == 6'h06 && cfgByteEnable[1])
         mSec = cfgWrData[15:8];
      if (!resetn) begin
         mFlag = 0;
         mLat = 0;
         mSec = 0;
      end
      @(posedge clock);
      #1;
      check(cfgRdValid, cfgRead & resetn);
      check(cfgRdData, expRd);
      check(hubLinkSerrMessage, expMsg);
      check(signaledSystemError, mFlag);
      check(secondaryBusNum, mSec);
      check(fwdToLink, resetn & fwdRequest & expFwd);
      check(fwdRefused, resetn & fwdRequest & ~expFwd);
   endtask

   initial begin
      clock = 0;
      forever #50 clock = ~clock;
   end

   initial begin
      seed = 32'hc364;
      errTotal = 0;
      checksDone = 0;
      mFlag = 0;
      mLat = 0;
      mSec = 0;
      resetn = 0;
      mainRevision = 8'h00;
      drive(1);
      cfgRead = 0;
      cfgWrite = 0;
      fwdRequest = 0;
      repeat (12) tick();
      resetn = 1;
      for (int i = 0; i < 4000; i++) begin
         // A second reset in mid-run must restore the defaults
         if (i == 2000)
            resetn = 0;
         if (i == 2003)
            resetn = 1;
         drive(i);
         tick();
      end
      endSim();
   end
endmodule
